// [pkg/pcg_consts.vh]
// Register offsets, field positions and reset values for the peripheral clock gating block.
// Assumes inclusion by its bare name from the design file.
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PCG_OFF_RUN2 12'h108
`define PCG_OFF_SLEEP2 12'h118
`define PCG_OFF_DEEP2 12'h128
`define PCG_OFF_DEEP1 12'h124
`define PCG_OFF_MODE 12'h060
`define PCG_OFF_FAULT_ADDR 12'h064
`define PCG_OFF_INT_STATUS 12'h068
`define PCG_OFF_INT_MASK 12'h06c
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define PCG_BIT_PHY 30
`define PCG_BIT_MAC 28
`define PCG_BIT_PORT_G 6
`define PCG_BIT_PORT_A 0
`define PCG_MASK_GROUP2 32'h5000_007f
`define PCG_MASK_GROUP1 32'h0000_0011
`define PCG_BIT_SSI_FIRST 4
`define PCG_BIT_UART_FIRST 0
`define PCG_BIT_AUTO_GATE 0
`define PCG_INT_FAULT 0
`define PCG_INT_MASK_ALL 32'h0000_0001
// ----------------------------------------
// Reset values and power modes
// ----------------------------------------
`define PCG_RESET_VALUE 32'h0000_0000
`define PCG_MODE_RUN 2'h0
`define PCG_MODE_SLEEP 2'h1
`define PCG_MODE_DEEP 2'h2
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2
`endif

// [design/pcg_clock_gate.v]
// Peripheral clock gating control: run, sleep and deep-sleep gate registers, bus fault check.
// Assumes AXI4-Lite register access on clk_sys, power mode and peripheral access strobes
// coming from same-domain logic, and glitch-free gate cells fed by the enable outputs.
//
// Overview of operation
// - A set gating bit lets the peripheral clock run normally.
// - A cleared gating bit stops that peripheral clock to save power.
// - Accesses to a group2 peripheral whose clock is gated answer with a bus fault.
// - All implemented gating bits reset to zero; group2 peripherals start unclocked, group1 units stay clocked.
// - Run register applies in run, sleep register in sleep, deep register in deep sleep.
// - Sleep and deep-sleep registers apply only when automatic gating is enabled.
// - Bit 30 gates the Ethernet PHY clock.
// - Bit 28 gates the Ethernet MAC clock.
// - Bits 6 down to 0 gate ports G down to A.
// - Reserved bits 31, 29 and 27:7 are read-only zero.
// - Deep-sleep group1: bit 4 sync serial, bit 0 async serial, bits 3:1 zero.
// - Run group2 register sits at 0x108, resets to zero.
// - Sleep group2 register sits at 0x118 with the run layout.
// - Deep-sleep group2 register sits at 0x128 with the run layout, reset zero.
//
// Register decode works on word indices: byte lanes below bit 2 never select a register.
// Group1 has no run register here, so its units stay clocked outside deep sleep.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "pcg_consts.vh"

module pcg_clock_gate (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // AXI4-Lite write address
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Power mode from the power controller
   input wire [1:0] power_mode,
   // Peripheral access check: one-hot target in group2 bit layout
   input wire [31:0] periph_sel,
   input wire periph_access,
   output reg periph_fault,
   // Clock enables to the gate cells
   output reg ethernet_phy_clk_en,
   output reg ethernet_mac_clk_en,
   output reg [6:0] port_clk_en,
   output reg sync_serial_first_clk_en,
   output reg async_serial_first_clk_en,
   // Interrupt
   output wire irq
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg [31:0] run_clock_gate_group2;
   reg [31:0] sleep_clock_gate_group2;
   reg [31:0] deep_sleep_clock_gate_group2;
   reg [31:0] deep_sleep_clock_gate_group1;
   reg [31:0] run_clock_gate_group1;
   reg auto_clock_gating_enable;
   reg [31:0] fault_addr;
   reg [31:0] int_status;
   reg [31:0] int_mask;
   reg [31:0] next_gate2;
   reg [31:0] next_gate1;

   // Write channel holding registers; address and data may arrive in either order
   reg aw_held;
   reg w_held;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   function [31:0] apply_strb;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            apply_strb[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
         end
      end
   endfunction

   // ----------------------------------------
   // Register word indices
   // ----------------------------------------
   // Cut on purpose to the ten index bits the decoders compare against
   function [9:0] word_idx;
      input [11:0] off;
      begin
         word_idx = off[11:2];
      end
   endfunction

   localparam [9:0] idx_run2 = word_idx(`PCG_OFF_RUN2);
   localparam [9:0] idx_sleep2 = word_idx(`PCG_OFF_SLEEP2);
   localparam [9:0] idx_deep2 = word_idx(`PCG_OFF_DEEP2);
   localparam [9:0] idx_deep1 = word_idx(`PCG_OFF_DEEP1);
   localparam [9:0] idx_mode = word_idx(`PCG_OFF_MODE);
   localparam [9:0] idx_fault_addr = word_idx(`PCG_OFF_FAULT_ADDR);
   localparam [9:0] idx_int_status = word_idx(`PCG_OFF_INT_STATUS);
   localparam [9:0] idx_int_mask = word_idx(`PCG_OFF_INT_MASK);

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire have_aw = aw_held || aw_fire;
   wire have_w = w_held || w_fire;
   wire [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   wire do_write = have_aw && have_w && !s_axi_bvalid;
   wire [31:0] sel_fault = periph_sel & ~next_gate2;
   wire fault_event = periph_access && (sel_fault != 32'h0000_0000);

   function wr_hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         wr_hit = do_write && (addr[11:2] == off[11:2]);
      end
   endfunction

   function mapped;
      input [11:0] addr;
      begin
         case (addr[11:2])
            idx_run2, idx_sleep2, idx_deep2, idx_deep1: mapped = 1'b1;
            idx_mode, idx_fault_addr, idx_int_status, idx_int_mask: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Write path
   // ----------------------------------------
   // Either half may wait in its holding register; the response waits for both.
   // A write to the read-only fault address is accepted and ignored.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PCG_RESP_OKAY;
         run_clock_gate_group2 <= `PCG_RESET_VALUE;
         sleep_clock_gate_group2 <= `PCG_RESET_VALUE;
         deep_sleep_clock_gate_group2 <= `PCG_RESET_VALUE;
         deep_sleep_clock_gate_group1 <= `PCG_RESET_VALUE;
         auto_clock_gating_enable <= 1'b0;
         int_mask <= `PCG_RESET_VALUE;
      end else begin
         if (aw_fire && !do_write) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_fire && !do_write) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wr_addr) ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Reserved bits masked off so they always read zero
         if (wr_hit(wr_addr, `PCG_OFF_RUN2))
            run_clock_gate_group2 <= apply_strb(run_clock_gate_group2, wr_data, wr_strb)
                                     & `PCG_MASK_GROUP2;
         if (wr_hit(wr_addr, `PCG_OFF_SLEEP2))
            sleep_clock_gate_group2 <= apply_strb(sleep_clock_gate_group2, wr_data, wr_strb)
                                       & `PCG_MASK_GROUP2;
         if (wr_hit(wr_addr, `PCG_OFF_DEEP2))
            deep_sleep_clock_gate_group2 <= apply_strb(deep_sleep_clock_gate_group2, wr_data, wr_strb)
                                            & `PCG_MASK_GROUP2;
         if (wr_hit(wr_addr, `PCG_OFF_DEEP1))
            deep_sleep_clock_gate_group1 <= apply_strb(deep_sleep_clock_gate_group1, wr_data, wr_strb)
                                            & `PCG_MASK_GROUP1;
         if (wr_hit(wr_addr, `PCG_OFF_MODE) && wr_strb[0])
            auto_clock_gating_enable <= wr_data[`PCG_BIT_AUTO_GATE];
         if (wr_hit(wr_addr, `PCG_OFF_INT_MASK))
            int_mask <= apply_strb(int_mask, wr_data, wr_strb) & `PCG_INT_MASK_ALL;
      end
   end

   // ----------------------------------------
   // Fault capture and interrupt status
   // ----------------------------------------
   // Fault check uses the enable about to be registered, so a write that gates
   // a unit off faults an access in the very next cycle.
   wire w1c_status = wr_hit(wr_addr, `PCG_OFF_INT_STATUS) && wr_strb[0] && wr_data[`PCG_INT_FAULT];

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         int_status <= `PCG_RESET_VALUE;
         fault_addr <= `PCG_RESET_VALUE;
         periph_fault <= 1'b0;
      end else begin
         periph_fault <= fault_event;
         if (fault_event) begin
            // Set beats a simultaneous clear so no fault is lost
            int_status[`PCG_INT_FAULT] <= 1'b1;
            fault_addr <= periph_sel;
         end else if (w1c_status) begin
            int_status[`PCG_INT_FAULT] <= 1'b0;
         end
      end
   end

   assign irq = |(int_status & int_mask);

   // ----------------------------------------
   // Mode selection and clock enables
   // ----------------------------------------
   // Group1 run register lies outside this block; the run value is all-on here for group1.
   always @* begin
      run_clock_gate_group1 = `PCG_MASK_GROUP1;
      next_gate2 = run_clock_gate_group2;
      next_gate1 = run_clock_gate_group1;
      if (auto_clock_gating_enable) begin
         case (power_mode)
            `PCG_MODE_RUN: begin
               next_gate2 = run_clock_gate_group2;
               next_gate1 = run_clock_gate_group1;
            end
            `PCG_MODE_SLEEP: begin
               next_gate2 = sleep_clock_gate_group2;
               next_gate1 = run_clock_gate_group1;
            end
            `PCG_MODE_DEEP: begin
               next_gate2 = deep_sleep_clock_gate_group2;
               next_gate1 = deep_sleep_clock_gate_group1;
            end
            default: begin
               next_gate2 = run_clock_gate_group2;
               next_gate1 = run_clock_gate_group1;
            end
         endcase
      end
   end

   // Registered enables keep the gate-cell inputs free of decode glitches
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ethernet_phy_clk_en <= 1'b0;
         ethernet_mac_clk_en <= 1'b0;
         port_clk_en <= 7'h00;
         sync_serial_first_clk_en <= 1'b0;
         async_serial_first_clk_en <= 1'b0;
      end else begin
         ethernet_phy_clk_en <= next_gate2[`PCG_BIT_PHY];
         ethernet_mac_clk_en <= next_gate2[`PCG_BIT_MAC];
         port_clk_en <= next_gate2[`PCG_BIT_PORT_G:`PCG_BIT_PORT_A];
         sync_serial_first_clk_en <= next_gate1[`PCG_BIT_SSI_FIRST];
         async_serial_first_clk_en <= next_gate1[`PCG_BIT_UART_FIRST];
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   reg [31:0] next_rdata;
   reg [1:0] next_rresp;

   // Unmapped words read as zero with a slave error
   always @* begin
      next_rdata = 32'h0000_0000;
      next_rresp = `PCG_RESP_OKAY;
      case (s_axi_araddr[11:2])
         idx_run2: next_rdata = run_clock_gate_group2;
         idx_sleep2: next_rdata = sleep_clock_gate_group2;
         idx_deep2: next_rdata = deep_sleep_clock_gate_group2;
         idx_deep1: next_rdata = deep_sleep_clock_gate_group1;
         idx_mode: next_rdata = {31'h0000_0000, auto_clock_gating_enable};
         idx_fault_addr: next_rdata = fault_addr;
         idx_int_status: next_rdata = int_status;
         idx_int_mask: next_rdata = int_mask;
         default: next_rresp = `PCG_RESP_SLVERR;
      endcase
   end

   // Read data registered; arready drops while it waits for rready
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PCG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // pcg_clock_gate

// [test/pcg_clock_gate_checker.sv]
// Concurrent checks on the clock gating block's ports.
// Assumes binding to pcg_clock_gate; sees its ports only.
`timescale 1ns/10ps
module pcg_clock_gate_checker (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Register bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Fault check and enables
   input wire periph_access,
   input wire periph_fault,
   input wire ethernet_phy_clk_en,
   input wire ethernet_mac_clk_en,
   input wire [6:0] port_clk_en
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped before rready");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
      else $error("write response not one cycle after request");
   chk_fault_cause: assert property (periph_fault |-> $past(periph_access))
      else $error("fault without a peripheral access");
   chk_reset_zero: assert property ($rose(rstn) |-> !ethernet_phy_clk_en && !ethernet_mac_clk_en
      && port_clk_en == 7'h00)
      else $error("enables not zero out of reset");
endmodule // pcg_clock_gate_checker
bind pcg_clock_gate pcg_clock_gate_checker chk (.*);

// [test/pcg_clock_gate_bench.sv]
// Directed bench for the clock gating block over its register bus.
// Assumes the design, its constants header and the checker compiled first.
`timescale 1ns/10ps
`include "pcg_consts.vh"
module pcg_clock_gate_bench;
   localparam [1:0] ok = `PCG_RESP_OKAY;
   localparam [1:0] er = `PCG_RESP_SLVERR;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [31:0] periph_sel = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, periph_access = 1'b0;
   logic [1:0] power_mode = `PCG_MODE_RUN;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [6:0] port_clk_en;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_fault, irq;
   wire ethernet_phy_clk_en, ethernet_mac_clk_en, sync_serial_first_clk_en, async_serial_first_clk_en;
   integer err_count = 0;
   integer cmp_count = 0;
   integer i;
   always #5 clk_sys = ~clk_sys;
   pcg_clock_gate dut (.*);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task stop_test;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Bounded waits: a hung handshake ends the run
   task tmo(inout integer n);
      begin
         n = n + 1;
         if (n > 40) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t ns: bus timeout", $time);
            stop_test;
         end
      end
   endtask
   task wr(input [11:0] a, input [31:0] d, input [1:0] r);
      integer n;
      begin
         n = 0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (s_axi_awvalid !== 1'b0 || s_axi_wvalid !== 1'b0 || n == 0) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            tmo(n);
            @(negedge clk_sys);
         end
         do begin
            @(posedge clk_sys);
            tmo(n);
         end while (!s_axi_bvalid);
         cmp(s_axi_bresp, r);
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [31:0] d, input [1:0] r);
      integer n;
      begin
         n = 0;
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge clk_sys);
            tmo(n);
         end while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do begin
            @(posedge clk_sys);
            tmo(n);
         end while (!s_axi_rvalid);
         cmp(s_axi_rdata, d);
         cmp(s_axi_rresp, r);
         s_axi_rready <= 1'b0;
      end
   endtask
   // Enables are registered: let them settle
   task en(input [10:0] e);
      begin
         repeat (2) @(posedge clk_sys);
         cmp({ethernet_phy_clk_en, ethernet_mac_clk_en, port_clk_en, sync_serial_first_clk_en,
            async_serial_first_clk_en}, e);
      end
   endtask
   task pulse(input f);
      begin
         periph_access <= 1'b1;
         @(posedge clk_sys);
         periph_access <= 1'b0;
         @(posedge clk_sys);
         cmp(periph_fault, f);
      end
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      rd(`PCG_OFF_RUN2, `PCG_RESET_VALUE, ok);
      rd(`PCG_OFF_SLEEP2, `PCG_RESET_VALUE, ok);
      rd(`PCG_OFF_DEEP2, `PCG_RESET_VALUE, ok);
      rd(`PCG_OFF_DEEP1, `PCG_RESET_VALUE, ok);
      rd(`PCG_OFF_MODE, `PCG_RESET_VALUE, ok);
      en(11'h003);
      $display("Test reset values done");
      wr(`PCG_OFF_RUN2, 32'hffff_ffff, ok);
      rd(`PCG_OFF_RUN2, `PCG_MASK_GROUP2, ok);
      en(11'h7ff);
      for (i = 0; i < 7; i = i + 1) begin
         wr(`PCG_OFF_RUN2, 32'h0000_0001 << i, ok);
         en(11'h003 | (11'h004 << i));
      end
      wr(`PCG_OFF_RUN2, 32'h1000_0000, ok);
      en(11'h203);
      wr(`PCG_OFF_RUN2, 32'h4000_0000, ok);
      en(11'h403);
      $display("Test field map done");
      periph_sel <= 32'h1000_0000;
      pulse(1'b1);
      rd(`PCG_OFF_FAULT_ADDR, 32'h1000_0000, ok);
      rd(`PCG_OFF_INT_STATUS, 32'h0000_0001, ok);
      cmp(irq, 1'b0);
      wr(`PCG_OFF_INT_MASK, 32'h0000_0001, ok);
      cmp(irq, 1'b1);
      wr(`PCG_OFF_INT_STATUS, 32'h0000_0001, ok);
      cmp(irq, 1'b0);
      periph_sel <= 32'h4000_0000;
      pulse(1'b0);
      $display("Test bus fault done");
      wr(`PCG_OFF_RUN2, 32'h0000_0001, ok);
      wr(`PCG_OFF_SLEEP2, 32'h0000_0002, ok);
      wr(`PCG_OFF_DEEP2, 32'h0000_0004, ok);
      wr(`PCG_OFF_DEEP1, 32'hffff_ffff, ok);
      rd(`PCG_OFF_DEEP1, `PCG_MASK_GROUP1, ok);
      power_mode <= `PCG_MODE_SLEEP;
      en(11'h007);
      wr(`PCG_OFF_MODE, 32'h0000_0001, ok);
      en(11'h00b);
      power_mode <= `PCG_MODE_DEEP;
      en(11'h013);
      wr(`PCG_OFF_DEEP1, 32'h0000_0010, ok);
      en(11'h012);
      power_mode <= `PCG_MODE_RUN;
      en(11'h007);
      $display("Test power modes done");
      wr(12'h200, 32'h0000_0001, er);
      rd(12'h200, 32'h0000_0000, er);
      $display("Test unmapped access done");
      stop_test;
   end
endmodule // pcg_clock_gate_bench
